// ---- rtl/smd_decoder.sv ----
// address decoder for code, quad-spi, otp and internal sram regions
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// How it works
// - address space alternates 256MB non-secure and secure aliases.
// - debug areas at the top of the map skip the alias fold.
// - four 512KB code sram banks from 0x0, secure at 0x1000_0000.
// - 8MB quad-spi window 0x0020_0000..0x009F_FFFF goes to flash.
// - direct flash reads reach only the lowest 256KB.
// - otp emulation registers at 0x0E00_0000..0x0E00_00FF.
// - 32KB internal sram bank 0 at 0x2000_0000 and 0x3000_0000.
// - every register bit clears to zero on reset.
// - 32KB internal sram bank 1 at 0x2000_8000 and 0x3000_8000.
// ----------------------------------------------------------------------
module smd_decoder
  import smd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic write_i,
  input wire logic [smd_pkg::ADDR_W-1:0] addr_i,
  output logic [smd_pkg::TGT_N-1:0] sel_o,
  output logic secure_o,
  output logic [smd_pkg::ADDR_W-1:0] offset_o,
  output logic [1:0] code_bank_o,
  output logic valid_o,
  output logic err_o,
  output logic ready_o
);
  import smd_pkg::*;

  // --------------------------------------------------------------------
  // region decode
  // --------------------------------------------------------------------
  function automatic logic in_range(input logic [31:0] a,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  wire logic is_dbg = (addr_i >= DBG_BASE);
  wire logic [31:0] fold_addr = is_dbg ? addr_i
                                       : (addr_i & ALIAS_MASK);
  wire logic is_sec = !is_dbg && addr_i[SEC_BIT];
  wire logic hit_code = in_range(fold_addr, CODE_BASE, CODE_LAST);
  wire logic hit_qspi = in_range(fold_addr, QSPI_BASE, QSPI_LAST);
  wire logic [31:0] qspi_off = fold_addr - QSPI_BASE;
  wire logic qspi_ok = hit_qspi && (qspi_off < QSPI_DIRECT_SIZE);
  wire logic hit_otp = in_range(fold_addr, OTP_BASE, OTP_LAST);
  wire logic hit_is0 = in_range(fold_addr, ISRAM0_BASE, ISRAM0_LAST);
  wire logic hit_is1 = in_range(fold_addr, ISRAM1_BASE, ISRAM1_LAST);
  wire logic [1:0] bank = fold_addr[CODE_BANK_LSB +: 2];
  wire logic mapped = hit_code || qspi_ok || hit_otp || hit_is0
                      || hit_is1 || is_dbg;

  logic [TGT_N-1:0] sel_d;
  logic [31:0] off_d;

  always_comb begin
    sel_d = '0;
    off_d = '0;
    if (is_dbg) begin
      sel_d[T_DBG] = 1'b1;
      off_d = addr_i - DBG_BASE;
    end else if (hit_code) begin
      sel_d[T_CODE0 + int'(bank)] = 1'b1;
      off_d = fold_addr - CODE_BASE;
    end else if (qspi_ok) begin
      sel_d[T_QSPI] = 1'b1;
      off_d = qspi_off;
    end else if (hit_otp) begin
      sel_d[T_OTP] = 1'b1;
      off_d = fold_addr - OTP_BASE;
    end else if (hit_is0) begin
      sel_d[T_ISRAM0] = 1'b1;
      off_d = fold_addr - ISRAM0_BASE;
    end else if (hit_is1) begin
      sel_d[T_ISRAM1] = 1'b1;
      off_d = fold_addr - ISRAM1_BASE;
    end
  end

  // --------------------------------------------------------------------
  // default error target
  // --------------------------------------------------------------------
  wire logic err_busy;
  wire logic err_done;
  wire logic take = req_i && !err_busy;
  wire logic err_req = take && !mapped;

  smd_err_slave u_err (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .req_i(err_req),
    .busy_o(err_busy),
    .done_o(err_done)
  );

  // --------------------------------------------------------------------
  // registered outputs
  // --------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sel_o <= '0;
      secure_o <= 1'b0;
      offset_o <= '0;
      code_bank_o <= '0;
      valid_o <= 1'b0;
      err_o <= 1'b0;
      ready_o <= 1'b0;
    end else begin
      sel_o <= (take && mapped) ? sel_d : '0;
      secure_o <= take && mapped && is_sec;
      offset_o <= (take && mapped) ? off_d : '0;
      code_bank_o <= (take && hit_code && !is_dbg) ? bank : 2'h0;
      valid_o <= take && mapped;
      err_o <= err_done;
      ready_o <= !err_busy && !err_req;
    end
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  property p_secure_alias;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (req_i && !err_busy && addr_i[SEC_BIT] && addr_i < DBG_BASE && mapped)
      |=> secure_o;
  endproperty
  a_secure_alias: assert property (p_secure_alias)
    else $error("secure alias not flagged");

  property p_dbg_plain;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (req_i && !err_busy && addr_i >= DBG_BASE)
      |=> (sel_o[T_DBG] && !secure_o);
  endproperty
  a_dbg_plain: assert property (p_dbg_plain)
    else $error("debug area remapped");

  property p_code3;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (take && fold_addr >= CODE_BANK3 && fold_addr <= CODE_LAST && !is_dbg)
      |=> (sel_o[T_CODE0 + 3] && code_bank_o == 2'h3);
  endproperty
  a_code3: assert property (p_code3)
    else $error("code bank 3 misdecoded");

  property p_qspi_direct;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (take && !is_dbg && fold_addr == QSPI_BASE)
      |=> (sel_o[T_QSPI] && offset_o == 32'h0000_0000);
  endproperty
  a_qspi_direct: assert property (p_qspi_direct)
    else $error("flash base not routed");

  property p_qspi_limit;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (take && hit_qspi && qspi_off >= QSPI_DIRECT_SIZE)
      |=> (!sel_o[T_QSPI] ##1 1'b1 ##1 err_o);
  endproperty
  a_qspi_limit: assert property (p_qspi_limit)
    else $error("flash read beyond 256KB allowed");

  property p_otp;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (take && hit_otp) |=> sel_o[T_OTP];
  endproperty
  a_otp: assert property (p_otp)
    else $error("otp block misdecoded");

  property p_isram;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (take && (hit_is0 || hit_is1))
      |=> (sel_o[T_ISRAM0] || sel_o[T_ISRAM1]) && offset_o < 32'h0000_8000;
  endproperty
  a_isram: assert property (p_isram)
    else $error("internal sram misdecoded");

  property p_unmapped;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (take && !mapped) |=> (!valid_o && !ready_o) ##2 (err_o && !ready_o);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not errored");

  property p_refuse_busy;
    @(posedge mclk_i) disable iff (!rst_n_i)
    err_busy |-> !ready_o ##1 !valid_o;
  endproperty
  a_refuse_busy: assert property (p_refuse_busy)
    else $error("request taken while error target busy");

  property p_isram1;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (take && hit_is1) |=> (sel_o[T_ISRAM1] && !sel_o[T_ISRAM0]);
  endproperty
  a_isram1: assert property (p_isram1)
    else $error("internal sram bank 1 misdecoded");

  property p_isram0_sec;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (take && hit_is0 && addr_i[SEC_BIT]) |=> (sel_o[T_ISRAM0] && secure_o);
  endproperty
  a_isram0_sec: assert property (p_isram0_sec)
    else $error("secure internal sram alias misdecoded");

  // outputs read zero on the edge after any reset cycle
  property p_reset_clear;
    @(posedge mclk_i)
    !rst_n_i |=> (sel_o == '0 && offset_o == '0 && code_bank_o == 2'h0
                  && !secure_o && !valid_o && !err_o && !ready_o);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("outputs not cleared by reset");

  property p_onehot;
    @(posedge mclk_i) disable iff (!rst_n_i)
    valid_o |-> $onehot(sel_o);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("select not one-hot");

  c_secure: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    valid_o && secure_o);
  c_qspi: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    sel_o[T_QSPI]);
  c_err: cover property (@(posedge mclk_i) disable iff (!rst_n_i) err_o);
  c_dbg: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    sel_o[T_DBG]);

endmodule

// ---- rtl/smd_err_slave.sv ----
// default target: answers an unmapped transfer with a two-cycle error
`timescale 1ns/100ps
module smd_err_slave
  import smd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  output logic busy_o,
  output logic done_o
);

  typedef enum logic [1:0] {
    SMD_E_IDLE,
    SMD_E_FIRST,
    SMD_E_SECOND
  } smd_estate_t;

  smd_estate_t state_q;
  smd_estate_t state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      SMD_E_IDLE: begin
        if (req_i) begin
          state_d = SMD_E_FIRST;
        end
      end
      SMD_E_FIRST: begin
        state_d = SMD_E_SECOND;
      end
      SMD_E_SECOND: begin
        state_d = SMD_E_IDLE;
      end
      default: begin
        state_d = SMD_E_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_q <= SMD_E_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign busy_o = (state_q != SMD_E_IDLE);
  assign done_o = (state_q == SMD_E_SECOND);

endmodule

// ---- rtl/smd_pkg.sv ----
// constants and types shared by the secure memory map decoder
package smd_pkg;

  localparam int ADDR_W = 32;

  // alias structure: bit 28 selects the secure alias of each 512MB pair
  localparam int SEC_BIT = 28;
  localparam logic [31:0] ALIAS_MASK = 32'hEFFF_FFFF;

  // debug areas kept out of the alias fold (system region and up)
  localparam logic [31:0] DBG_BASE = 32'hE000_0000;

  // code sram: four banks of 512KB from the non-secure base
  localparam logic [31:0] CODE_BASE = 32'h0000_0000;
  localparam logic [31:0] CODE_LAST = 32'h001F_FFFF;
  localparam int CODE_BANK_LSB = 19;
  localparam logic [31:0] CODE_BANK3 = 32'h0018_0000;

  // quad-spi flash: 8MB window, 256KB directly readable
  localparam logic [31:0] QSPI_BASE = 32'h0020_0000;
  localparam logic [31:0] QSPI_LAST = 32'h009F_FFFF;
  localparam logic [31:0] QSPI_DIRECT_SIZE = 32'h0004_0000;

  // otp emulation registers
  localparam logic [31:0] OTP_BASE = 32'h0E00_0000;
  localparam logic [31:0] OTP_LAST = 32'h0E00_00FF;

  // internal sram banks of 32KB each
  localparam logic [31:0] ISRAM0_BASE = 32'h2000_0000;
  localparam logic [31:0] ISRAM0_LAST = 32'h2000_7FFF;
  localparam logic [31:0] ISRAM1_BASE = 32'h2000_8000;
  localparam logic [31:0] ISRAM1_LAST = 32'h2000_FFFF;

  // one-hot target positions
  localparam int TGT_N = 9;
  localparam int T_CODE0 = 0;
  localparam int T_QSPI = 4;
  localparam int T_OTP = 5;
  localparam int T_ISRAM0 = 6;
  localparam int T_ISRAM1 = 7;
  localparam int T_DBG = 8;

  typedef enum logic [3:0] {
    SMD_TGT_CODE0,
    SMD_TGT_CODE1,
    SMD_TGT_CODE2,
    SMD_TGT_CODE3,
    SMD_TGT_QSPI,
    SMD_TGT_OTP,
    SMD_TGT_ISRAM0,
    SMD_TGT_ISRAM1,
    SMD_TGT_DBG,
    SMD_TGT_DEFAULT
  } smd_tgt_t;

endpackage

// ---- verification/smd_decoder_test.sv ----
// self-checking testbench for the secure memory map decoder
`timescale 1ns/100ps
module smd_decoder_test;
  import smd_pkg::*;
  typedef struct {
    logic [13:0] v;
    logic [13:0] m;
    logic [31:0] o;
    bit co;
  } smd_exp_t;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req, write, secure_o, valid_o, err_o, ready_o;
  logic [31:0] addr, offset_o, r;
  logic [TGT_N-1:0] sel_o;
  logic [1:0] code_bank_o;
  int error_cnt = 0;
  int comparisons = 0;
  int seed = 32'h14b5348f;
  smd_exp_t exp_q[$];
  smd_exp_t mon_e;
  logic [31:0] dir_a [20] = '{32'h0000_0000, 32'h0008_0004, 32'h1010_0008,
    32'h0018_0000, 32'h101F_FFFC, 32'h0020_0000, 32'h1023_FFFC,
    32'h0024_0000, 32'h009F_FFFC, 32'h0E00_00FC, 32'h1E00_0000,
    32'h0E00_0100, 32'h2000_7FFC, 32'h3000_0000, 32'h2000_8000,
    32'h3000_FFFC, 32'h2001_0000, 32'h4000_0000, 32'hE000_0010,
    32'hF000_0000};

  always #50 mclk_i = ~mclk_i;

  smd_master m (.mclk_i(mclk_i), .ready_i(ready_o), .req_o(req),
    .write_o(write), .addr_o(addr));

  smd_decoder dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(req),
    .write_i(write), .addr_i(addr), .sel_o(sel_o), .secure_o(secure_o),
    .offset_o(offset_o), .code_bank_o(code_bank_o), .valid_o(valid_o),
    .err_o(err_o), .ready_o(ready_o));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // packs {valid, err, sel, secure, bank} as the decoder should answer
  function automatic smd_exp_t predict(input logic [31:0] a);
    smd_exp_t e;
    logic [31:0] f;
    int t;
    f = a & ALIAS_MASK;
    t = -1;
    e = '{14'h0, 14'h3FFF, 32'h0, 1'b1};
    if (a >= DBG_BASE) begin
      t = T_DBG;
      e.o = a - DBG_BASE;
    end else if (f <= CODE_LAST) begin
      t = T_CODE0 + int'(f[20:19]);
      e.v[1:0] = f[20:19];
      e.o = f - CODE_BASE;
    end else if (f >= QSPI_BASE && f < QSPI_BASE + QSPI_DIRECT_SIZE) begin
      t = T_QSPI;
      e.o = f - QSPI_BASE;
    end else if (f >= OTP_BASE && f <= OTP_LAST) begin
      t = T_OTP;
      e.o = f - OTP_BASE;
    end else if (f >= ISRAM0_BASE && f <= ISRAM1_LAST) begin
      t = (f > ISRAM0_LAST) ? T_ISRAM1 : T_ISRAM0;
      e.o = f - ((f > ISRAM0_LAST) ? ISRAM1_BASE : ISRAM0_BASE);
    end
    if (t < 0) begin
      e = '{14'h1000, 14'h3000, 32'h0, 1'b0};
    end else begin
      e.v[13] = 1'b1;
      e.v[3 + t] = 1'b1;
      e.v[2] = (a < DBG_BASE) && a[SEC_BIT];
    end
    return e;
  endfunction

  task automatic go(input logic [31:0] a);
    bit ok;
    exp_q.push_back(predict(a));
    r = $random(seed);
    m.access(a, r[0], ok);
    if (!ok) begin
      error_cnt++;
      end_of_test();
    end
  endtask

  // monitor: every answer takes the oldest note
  always @(negedge mclk_i) begin
    if (rst_n_i && (valid_o === 1'b1 || err_o === 1'b1)) begin
      if (exp_q.size() == 0) begin
        cmp(32'h1, 32'h0);
      end else begin
        mon_e = exp_q.pop_front();
        cmp({31'h0, ready_o}, {31'h0, valid_o});
        cmp({18'h0, {valid_o, err_o, sel_o, secure_o, code_bank_o} & mon_e.m},
          {18'h0, mon_e.v & mon_e.m});
        if (mon_e.co) begin
          cmp(offset_o, mon_e.o);
        end
      end
    end
  end

  initial begin
    repeat (6) @(negedge mclk_i);
    cmp({20'h0, ready_o, valid_o, err_o, sel_o}, 32'h0);
    cmp(offset_o | {29'h0, secure_o, code_bank_o}, 32'h0);
    rst_n_i = 1'b1;
    $display("reset test done");
    foreach (dir_a[i]) begin
      go(dir_a[i]);
    end
    $display("directed map test done");
    repeat (30) begin
      r = $random(seed);
      go((r & 32'h1000_7FFC) | ISRAM0_BASE);
      go((r & 32'h1003_FFFC) | QSPI_BASE);
      go({r[31:2], 2'b00});
    end
    m.release_bus();
    for (int n = 0; n < 20 && exp_q.size() > 0; n++) begin
      @(negedge mclk_i);
    end
    cmp(exp_q.size(), 32'h0);
    $display("random map test done");
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge mclk_i);
    error_cnt++;
    end_of_test();
  end
endmodule

// ---- verification/smd_master.sv ----
// bus master model standing for the processor subsystem
`timescale 1ns/100ps
module smd_master (
  input wire logic mclk_i,
  input wire logic ready_i,
  output logic req_o,
  output logic write_o,
  output logic [31:0] addr_o
);
  initial begin
    req_o = 1'b0;
    write_o = 1'b0;
    addr_o = 32'h0000_0000;
  end

  // one transfer: wait for ready, then hold until the taking edge
  task automatic access(input logic [31:0] a, input logic w, output bit ok);
    int n;
    n = 0;
    @(negedge mclk_i);
    while (ready_i !== 1'b1 && n < 20) begin
      req_o = 1'b0;
      addr_o = ~addr_o;
      @(negedge mclk_i);
      n++;
    end
    ok = (n < 20);
    req_o = ok;
    // direction only: no data lane, so no register bits are written
    write_o = w;
    addr_o = {a[31:2], 2'b00};
    @(posedge mclk_i);
  endtask

  // a released bus shows no stale address
  task automatic release_bus();
    @(negedge mclk_i);
    req_o = 1'b0;
    addr_o = ~addr_o;
  endtask
endmodule
